// ===== rtl/timer16_pkg.sv
// Purpose: constants of the 16-bit timer register block
// Assumes: 8-bit register bus, I/O offsets 0x00-0x3F
// Notes:   offsets are I/O offsets; data space adds 0x20
package timer16_pkg;
  // ==========================================================
  // address map
  localparam logic [7:0] IO_SPAN      = 8'h40;  // i/o window size
  localparam logic [7:0] DATA_OFS     = 8'h20;  // data-space shift
  localparam logic [5:0] OFS_CAP_LO   = 6'h26;  // capture_value_low
  localparam logic [5:0] OFS_CAP_HI   = 6'h27;  // capture_value_high
  localparam logic [5:0] OFS_CMPB_LO  = 6'h28;  // compare_b_value_low
  localparam logic [5:0] OFS_CMPB_HI  = 6'h29;  // compare_b_value_high
  localparam logic [5:0] OFS_CMPA_LO  = 6'h2A;  // compare_a_value_low
  localparam logic [5:0] OFS_CMPA_HI  = 6'h2B;  // compare_a_value_high
  localparam logic [5:0] OFS_CNT_LO   = 6'h2C;  // counter low byte
  localparam logic [5:0] OFS_CNT_HI   = 6'h2D;  // counter_value_high
  localparam logic [5:0] OFS_FLAGS    = 6'h38;  // timer_event_flags
  localparam logic [5:0] OFS_IEN      = 6'h39;  // timer_irq_enables
  // ==========================================================
  // field positions and masks
  localparam int         BIT_CAP      = 5;      // capture bit
  localparam int         BIT_CMPA     = 4;      // compare a bit
  localparam int         BIT_CMPB     = 3;      // compare b bit
  localparam int         BIT_OVF      = 2;      // overflow bit
  localparam logic [7:0] FIELD_MASK   = 8'h3C;  // implemented bits
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  // ==========================================================
  // counter landmarks
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
endpackage

// ===== rtl/timer_cmp_if.sv
// Purpose: carrier between the register block and a compare channel
// Assumes: single clock, all signals in core_clk_i domain
// Notes:   one instance per compare channel
`timescale 1ns/10ps
interface timer_cmp_if;
  logic        tick;          // timer clock enable
  logic [15:0] counter;       // live counter value
  logic [15:0] compare;       // committed compare value
  logic        block;         // suppress next match
  logic        force_strobe;  // forced compare, output only
  logic        flag_set;      // one-cycle flag set pulse
  logic        wave;          // waveform output level
  modport regs (output tick, counter, compare, block, force_strobe,
                input flag_set, wave);
  modport chan (input tick, counter, compare, block, force_strobe,
                output flag_set, wave);
endinterface // timer_cmp_if

// ===== rtl/compare_channel.sv
// Purpose: one 16-bit compare channel with toggle output
// Assumes: tick is a one-cycle enable
// Notes:   flag pulse lands on the tick after the equal tick
`timescale 1ns/10ps
module compare_channel (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // channel carrier
  timer_cmp_if.chan cmp
);
  // ==========================================================
  // state
  typedef struct packed {
    logic match;     // equality seen on last tick
    logic flag_set;  // flag set pulse
    logic wave;      // output level
  } chan_state_t;
  chan_state_t s_q;
  chan_state_t s_d;

  // next state
  always_comb begin
    s_d = s_q;
    s_d.flag_set = 1'b0;
    if (cmp.tick) begin
      // compare every timer clock, unless a counter write blocks it
      s_d.match = (cmp.counter == cmp.compare) && !cmp.block;
      s_d.flag_set = s_q.match;
    end
    // match or forced strobe toggles the pin; force never sets a flag
    if ((cmp.tick && s_q.match) || cmp.force_strobe) begin
      s_d.wave = !s_q.wave;
    end
  end

  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmp.flag_set = s_q.flag_set;
  assign cmp.wave     = s_q.wave;
endmodule // compare_channel

// ===== rtl/capture_unit.sv
// Purpose: capture event detector with pin synchroniser
// Assumes: pin and comparator are asynchronous to core_clk_i
// Notes:   event pulse is three cycles after the pin edge
`timescale 1ns/10ps
module capture_unit (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // event sources
  input  wire logic pin_i,
  input  wire logic comparator_i,
  // configuration
  input  wire logic use_comparator_i,
  input  wire logic rising_i,
  input  wire logic disconnect_i,
  // result
  output logic      event_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic pin_s1;  // pin first stage
    logic pin_s2;  // pin second stage
    logic cmp_s1;  // comparator first stage
    logic cmp_s2;  // comparator second stage
    logic prev;    // last selected level
    logic evt;     // event pulse
  } cap_state_t;
  cap_state_t s_q;
  cap_state_t s_d;
  logic       src;  // selected synchronised source

  // next state
  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.cmp_s1 = comparator_i;
    s_d.cmp_s2 = s_q.cmp_s1;
    src = use_comparator_i ? s_q.cmp_s2 : s_q.pin_s2;
    s_d.prev = src;
    // pin is cut off while capture serves as top
    s_d.evt = !disconnect_i &&
              (rising_i ? (src && !s_q.prev) : (!src && s_q.prev));
  end

  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_o = s_q.evt;
endmodule // capture_unit

// ===== rtl/timer16_compare_capture_regs.sv
// Purpose: register side of a 16-bit timer: compare, capture, flags
// Assumes: counter and control bits live outside, same clock
// Notes:   read data appears one cycle after the read strobe
//
// Overview of operation
// - compare both channels against counter every tick
// - compare high byte latched, both bytes commit together
// - capture read returns coherent bytes via latch
// - one shared high-byte latch for all registers
// - capture event copies counter into capture value
// - capture value may serve as counter top
// - capture pin disconnected while capture is top
// - interrupt needs enable, global enable and flag
// - capture enable bit 5, overflow bit 2
// - compare a enable bit 4, b bit 3
// - capture event sets capture flag, bit 5
// - capture-top mode sets capture flag at top
// - compare a flag, bit 4, tick after match
// - compare b flag, bit 3, tick after match
// - forced strobe drives output, never sets flag
// - overflow flag bit 2, set point per mode
// - flags clear on vector or written one
// - counter write blocks next tick's matches
// - i/o offset decode, data space plus 0x20
`timescale 1ns/10ps
module timer16_compare_capture_regs (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic [7:0]  bus_addr_i,
  input  wire logic        bus_data_space_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic [7:0]  bus_wdata_i,
  output logic      [7:0]  bus_rdata_o,
  // counter unit
  input  wire logic        timer_tick_i,
  input  wire logic [15:0] counter_value_i,
  output logic             counter_load_o,
  output logic      [15:0] counter_load_value_o,
  output logic      [15:0] counter_top_o,
  // control bits from the control registers
  input  wire logic [3:0]  waveform_mode_select_i,
  input  wire logic        capture_rising_edge_i,
  input  wire logic        capture_from_comparator_i,
  input  wire logic        force_compare_a_strobe_i,
  input  wire logic        force_compare_b_strobe_i,
  // pins and comparator
  input  wire logic        capture_input_pin_i,
  input  wire logic        comparator_out_i,
  output logic             waveform_output_pin_a_o,
  output logic             waveform_output_pin_b_o,
  // cpu interrupt controller
  input  wire logic        global_irq_enable_i,
  input  wire logic [3:0]  irq_vector_ack_i,
  output logic      [3:0]  irq_request_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  temp;      // shared high-byte latch
    logic [15:0] cmp_a;     // compare_a_value
    logic [15:0] cmp_b;     // compare_b_value
    logic [15:0] cap;       // capture_value
    logic [7:0]  ien;       // timer_irq_enables
    logic [7:0]  flags;     // timer_event_flags
    logic        block;     // match block after counter write
    logic [7:0]  rdata;     // read data
    logic [3:0]  irq;       // interrupt requests
    logic        load;      // counter load pulse
    logic [15:0] load_val;  // counter load value
    logic [15:0] top;       // current top value
    logic        wave_a;    // pin a copy
    logic        wave_b;    // pin b copy
  } regs_state_t;
  regs_state_t s_q;
  regs_state_t s_d;

  // ==========================================================
  // address decode
  logic [7:0] io_addr;   // address folded to i/o offset
  logic       io_hit;    // address inside the i/o window
  logic [5:0] ofs;       // register offset
  logic       wr;        // qualified write
  logic       rd;        // qualified read

  // fold data-space addresses onto i/o offsets
  always_comb begin
    if (bus_data_space_i) begin
      io_addr = bus_addr_i - timer16_pkg::DATA_OFS;
      io_hit  = (bus_addr_i >= timer16_pkg::DATA_OFS) &&
                (io_addr < timer16_pkg::IO_SPAN);
    end else begin
      io_addr = bus_addr_i;
      io_hit  = bus_addr_i < timer16_pkg::IO_SPAN;
    end
    ofs = io_addr[5:0];
    wr  = bus_wr_i && io_hit;
    rd  = bus_rd_i && io_hit;
  end

  // ==========================================================
  // mode decode
  logic       cap_is_top;  // capture value used as top
  logic [15:0] top_val;    // top for this mode
  logic       ovf_hit;     // overflow set point reached

  // top selection and overflow set point per mode
  always_comb begin
    cap_is_top = 1'b0;
    top_val    = timer16_pkg::CNT_MAX;
    case (waveform_mode_select_i)
      4'h1, 4'h5: begin
        top_val = timer16_pkg::TOP_8BIT;
      end
      4'h2, 4'h6: begin
        top_val = timer16_pkg::TOP_9BIT;
      end
      4'h3, 4'h7: begin
        top_val = timer16_pkg::TOP_10BIT;
      end
      4'h4, 4'h9, 4'hB, 4'hF: begin
        top_val = s_q.cmp_a;
      end
      4'h8, 4'hA, 4'hC, 4'hE: begin
        top_val    = s_q.cap;
        cap_is_top = 1'b1;
      end
      default: begin
        top_val = timer16_pkg::CNT_MAX;
      end
    endcase
    // where the overflow flag is set depends on the mode
    case (waveform_mode_select_i)
      4'h0, 4'h4, 4'hC: begin
        ovf_hit = counter_value_i == timer16_pkg::CNT_MAX;
      end
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: begin
        ovf_hit = counter_value_i == timer16_pkg::CNT_BOTTOM;
      end
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
        ovf_hit = counter_value_i == top_val;
      end
      default: begin
        ovf_hit = 1'b0;  // reserved mode never overflows
      end
    endcase
  end

  // ==========================================================
  // compare channels
  timer_cmp_if cmp_a_if ();
  timer_cmp_if cmp_b_if ();

  // both channels see the same counter and block
  assign cmp_a_if.tick         = timer_tick_i;
  assign cmp_a_if.counter      = counter_value_i;
  assign cmp_a_if.compare      = s_q.cmp_a;
  assign cmp_a_if.block        = s_q.block;
  assign cmp_a_if.force_strobe = force_compare_a_strobe_i;
  assign cmp_b_if.tick         = timer_tick_i;
  assign cmp_b_if.counter      = counter_value_i;
  assign cmp_b_if.compare      = s_q.cmp_b;
  assign cmp_b_if.block        = s_q.block;
  assign cmp_b_if.force_strobe = force_compare_b_strobe_i;

  // channel a
  compare_channel u_cmp_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .cmp        (cmp_a_if.chan)
  );

  // channel b
  compare_channel u_cmp_b (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .cmp        (cmp_b_if.chan)
  );

  // ==========================================================
  // capture source
  logic cap_event;  // one-cycle capture event

  // synchronised edge detector on pin or comparator
  capture_unit u_capture (
    .core_clk_i       (core_clk_i),
    .rst_i            (rst_i),
    .pin_i            (capture_input_pin_i),
    .comparator_i     (comparator_out_i),
    .use_comparator_i (capture_from_comparator_i),
    .rising_i         (capture_rising_edge_i),
    .disconnect_i     (cap_is_top),
    .event_o          (cap_event)
  );

  // ==========================================================
  // flag set and clear terms
  logic [7:0] flag_set;  // hardware set requests
  logic [7:0] flag_clr;  // vector or software clears

  // gather set and clear per bit
  always_comb begin
    flag_set = timer16_pkg::RST_BYTE;
    // capture event, or top reached when capture is top
    flag_set[timer16_pkg::BIT_CAP] = cap_event ||
      (cap_is_top && timer_tick_i &&
       counter_value_i == s_q.cap);
    flag_set[timer16_pkg::BIT_CMPA] = cmp_a_if.flag_set;
    flag_set[timer16_pkg::BIT_CMPB] = cmp_b_if.flag_set;
    flag_set[timer16_pkg::BIT_OVF]  = timer_tick_i && ovf_hit;
    // vector acks map onto bits 2..5 in order
    flag_clr = {2'h0, irq_vector_ack_i, 2'h0};
    // written ones clear, written zeros leave alone
    if (wr && ofs == timer16_pkg::OFS_FLAGS) begin
      flag_clr = flag_clr | bus_wdata_i;
    end
    flag_clr = flag_clr & timer16_pkg::FIELD_MASK;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.load  = 1'b0;
    s_d.rdata = timer16_pkg::RST_BYTE;
    // matches are blocked only for the tick after a counter write
    if (timer_tick_i) begin
      s_d.block = 1'b0;
    end
    // capture copies the running counter
    if (cap_event) begin
      s_d.cap = counter_value_i;
    end
    // cpu writes
    if (wr) begin
      case (ofs)
        // every high byte goes to the one shared latch
        timer16_pkg::OFS_CAP_HI,
        timer16_pkg::OFS_CMPB_HI,
        timer16_pkg::OFS_CMPA_HI,
        timer16_pkg::OFS_CNT_HI: begin
          s_d.temp = bus_wdata_i;
        end
        // low byte write commits latch and byte together
        timer16_pkg::OFS_CMPA_LO: begin
          s_d.cmp_a = {s_q.temp, bus_wdata_i};
        end
        timer16_pkg::OFS_CMPB_LO: begin
          s_d.cmp_b = {s_q.temp, bus_wdata_i};
        end
        timer16_pkg::OFS_CAP_LO: begin
          // a capture in the same cycle keeps the event
          if (!cap_event) begin
            s_d.cap = {s_q.temp, bus_wdata_i};
          end
        end
        timer16_pkg::OFS_CNT_LO: begin
          s_d.load     = 1'b1;
          s_d.load_val = {s_q.temp, bus_wdata_i};
          s_d.block    = 1'b1;
        end
        timer16_pkg::OFS_IEN: begin
          s_d.ien = bus_wdata_i & timer16_pkg::FIELD_MASK;
        end
        default: begin
          s_d.temp = s_q.temp;  // flags handled apart, others ignored
        end
      endcase
    end
    // cpu reads
    if (rd) begin
      case (ofs)
        // capture and counter low byte reads park the high byte in the latch
        timer16_pkg::OFS_CAP_LO: begin
          s_d.rdata = s_q.cap[7:0];
          s_d.temp  = s_q.cap[15:8];
        end
        timer16_pkg::OFS_CMPB_LO: begin
          s_d.rdata = s_q.cmp_b[7:0];
        end
        timer16_pkg::OFS_CMPB_HI: begin
          s_d.rdata = s_q.cmp_b[15:8];
        end
        timer16_pkg::OFS_CMPA_LO: begin
          s_d.rdata = s_q.cmp_a[7:0];
        end
        timer16_pkg::OFS_CMPA_HI: begin
          s_d.rdata = s_q.cmp_a[15:8];
        end
        timer16_pkg::OFS_CNT_LO: begin
          s_d.rdata = counter_value_i[7:0];
          s_d.temp  = counter_value_i[15:8];
        end
        // high byte read returns the latch
        timer16_pkg::OFS_CAP_HI,
        timer16_pkg::OFS_CNT_HI: begin
          s_d.rdata = s_q.temp;
        end
        timer16_pkg::OFS_FLAGS: begin
          s_d.rdata = s_q.flags;
        end
        timer16_pkg::OFS_IEN: begin
          s_d.rdata = s_q.ien;
        end
        default: begin
          s_d.rdata = timer16_pkg::RST_BYTE;  // unmapped reads zero
        end
      endcase
    end
    // sticky flags: a set in the clearing cycle wins
    s_d.flags = ((s_q.flags & ~flag_clr) | flag_set) &
                timer16_pkg::FIELD_MASK;
    // request needs enable, global enable and flag
    s_d.irq = s_q.ien[5:2] & s_q.flags[5:2] &
              {4{global_irq_enable_i}};
    s_d.top    = top_val;
    s_d.wave_a = cmp_a_if.wave;
    s_d.wave_b = cmp_b_if.wave;
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.top   <= timer16_pkg::CNT_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rdata_o             = s_q.rdata;
  assign counter_load_o          = s_q.load;
  assign counter_load_value_o    = s_q.load_val;
  assign counter_top_o           = s_q.top;
  assign waveform_output_pin_a_o = s_q.wave_a;
  assign waveform_output_pin_b_o = s_q.wave_b;
  assign irq_request_o           = s_q.irq;
endmodule // timer16_compare_capture_regs

// ===== sim/counter_unit_model.sv
// Purpose: counter unit standing beside the timer register block
// Assumes: same clock as the block, sync active-high reset
// Notes:   a cpu load wins over counting; wraps to zero at top
`timescale 1ns/10ps
module counter_unit_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // control from the block
  input  wire logic        tick_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_value_i,
  input  wire logic [15:0] top_i,
  // live count
  output logic      [15:0] count_o
);
  // ==========
  // count, load or wrap
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
    end else if (load_i) begin
      count_o <= load_value_i;
    end else if (tick_i) begin
      count_o <= (count_o == top_i) ? 16'h0000 : count_o + 16'h0001;
    end
  end
endmodule // counter_unit_model

// ===== sim/timer16_compare_capture_regs_assertions.sv
// Purpose: port checks of the timer register block
// Assumes: one clock, sync active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module timer16_compare_capture_regs_assertions (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic [7:0]  bus_addr_i,
  input  wire logic        bus_data_space_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic [7:0]  bus_rdata_o,
  // counter and pins
  input  wire logic        timer_tick_i,
  input  wire logic        counter_load_o,
  input  wire logic [15:0] counter_load_value_o,
  input  wire logic        force_compare_a_strobe_i,
  input  wire logic        waveform_output_pin_a_o,
  // interrupts
  input  wire logic        global_irq_enable_i,
  input  wire logic [3:0]  irq_vector_ack_i,
  input  wire logic [3:0]  irq_request_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // one i/o write to an offset
  sequence s_wr_io(logic [5:0] ofs);
    bus_wr_i && !bus_data_space_i && bus_addr_i == {2'b00, ofs};
  endsequence
  // high byte, one quiet cycle, then low byte of the counter
  sequence s_cnt_pair;
    s_wr_io(timer16_pkg::OFS_CNT_HI) ##1 !bus_wr_i && !bus_rd_i
      ##1 s_wr_io(timer16_pkg::OFS_CNT_LO);
  endsequence
  // ==========
  // properties
  property p_rdata_idle;
    !bus_rd_i |=> bus_rdata_o == 8'h00;
  endproperty
  property p_rdata_unmapped;
    bus_rd_i && !bus_data_space_i && bus_addr_i >= timer16_pkg::IO_SPAN |=> bus_rdata_o == 8'h00;
  endproperty
  property p_load_pair;
    s_cnt_pair |=> counter_load_o &&
      counter_load_value_o == {$past(bus_wdata_i, 3), $past(bus_wdata_i)};
  endproperty
  property p_load_cause;
    counter_load_o |-> $past(bus_wr_i);
  endproperty
  property p_load_data_space;
    bus_wr_i && bus_data_space_i && bus_addr_i == 8'h4C |=> counter_load_o;
  endproperty
  property p_irq_global;
    |irq_request_o |-> $past(global_irq_enable_i);
  endproperty
  property p_irq_mask_off;
    !global_irq_enable_i |=> irq_request_o == 4'h0;
  endproperty
  property p_force_pin;
    force_compare_a_strobe_i && !timer_tick_i |-> ##2 $changed(waveform_output_pin_a_o);
  endproperty
  property p_ack_clear;
    irq_vector_ack_i[2] && !timer_tick_i |=> ##1 !irq_request_o[2];
  endproperty
  a_rdata_idle:      assert property (p_rdata_idle) else $error("read data not idle");
  a_rdata_unmapped:  assert property (p_rdata_unmapped) else $error("unmapped read");
  a_load_pair:       assert property (p_load_pair) else $error("counter load value");
  a_load_cause:      assert property (p_load_cause) else $error("load without write");
  a_load_data_space: assert property (p_load_data_space) else $error("data-space load");
  a_irq_global:      assert property (p_irq_global) else $error("irq without global");
  a_irq_mask_off:    assert property (p_irq_mask_off) else $error("irq while masked");
  a_force_pin:       assert property (p_force_pin) else $error("forced pin no toggle");
  a_ack_clear:       assert property (p_ack_clear) else $error("ack did not clear");
endmodule // timer16_compare_capture_regs_assertions
bind timer16_compare_capture_regs timer16_compare_capture_regs_assertions u_assertions (.*);

// ===== sim/tb_timer16_compare_capture_regs.sv
// Purpose: self-checking bench of the timer register block
// Assumes: counter model beside the block, no ticks unless asked
// Notes:   bus strobes last one cycle with an idle cycle between
`timescale 1ns/10ps
module tb_timer16_compare_capture_regs;
  // ==========
  // design signals
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  bus_addr_i = 8'h00;
  logic        bus_data_space_i = 1'b0;
  logic        bus_wr_i = 1'b0;
  logic        bus_rd_i = 1'b0;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic [7:0]  bus_rdata_o;
  logic        timer_tick_i = 1'b0;
  logic [15:0] counter_value_i;
  logic        counter_load_o;
  logic [15:0] counter_load_value_o;
  logic [15:0] counter_top_o;
  logic [3:0]  waveform_mode_select_i = 4'h0;
  logic        capture_rising_edge_i = 1'b1;
  logic        capture_from_comparator_i = 1'b0;
  logic        force_compare_a_strobe_i = 1'b0;
  logic        force_compare_b_strobe_i = 1'b0;
  logic        capture_input_pin_i = 1'b0;
  logic        comparator_out_i = 1'b0;
  logic        waveform_output_pin_a_o;
  logic        waveform_output_pin_b_o;
  logic        global_irq_enable_i = 1'b0;
  logic [3:0]  irq_vector_ack_i = 4'h0;
  logic [3:0]  irq_request_o;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic        pin_a_old;
  logic [7:0]  reset_map [9] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h38, 8'h39};
  // ==========
  // clock, block and counter
  always #10 core_clk_i = ~core_clk_i;
  timer16_compare_capture_regs dut (.*);
  counter_unit_model u_counter (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .tick_i       (timer_tick_i),
    .load_i       (counter_load_o),
    .load_value_i (counter_load_value_o),
    .top_i        (counter_top_o),
    .count_o      (counter_value_i)
  );
  // ==========
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ds = 1'b0);
    @(posedge core_clk_i);
    bus_addr_i <= a;
    bus_data_space_i <= ds;
    bus_wdata_i <= d;
    bus_wr_i <= 1'b1;
    @(posedge core_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    bus_addr_i <= a;
    bus_data_space_i <= 1'b0;
    bus_rd_i <= 1'b1;
    @(posedge core_clk_i);
    bus_rd_i <= 1'b0;
    // data stands until this edge; read it before it drops
    @(posedge core_clk_i);
    check({8'h00, bus_rdata_o}, {8'h00, exp});
  endtask
  // high byte first, so the shared latch commits both together
  task automatic wr16(input logic [5:0] lo, input logic [15:0] v, input logic ds = 1'b0);
    logic [7:0] a;
    a = {2'b00, lo} + (ds ? timer16_pkg::DATA_OFS : 8'h00);
    wr(a + 8'h01, v[15:8], ds);
    wr(a, v[7:0], ds);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      timer_tick_i <= 1'b1;
    end
    @(posedge core_clk_i);
    timer_tick_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  // ==========
  // watchdog
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    foreach (reset_map[i]) rdchk(reset_map[i], 8'h00);
    rdchk(8'h3F, 8'h00);
    rdchk(8'h45, 8'h00);
    wr16(timer16_pkg::OFS_CMPA_LO, 16'h1234, 1'b1);
    rdchk(8'h2A, 8'h34);
    rdchk(8'h2B, 8'h12);
    wr16(timer16_pkg::OFS_CMPB_LO, 16'h1236);
    // first tick after the load is blocked, so only b matches
    wr16(timer16_pkg::OFS_CNT_LO, 16'h1234);
    ticks(4);
    rdchk(8'h38, 8'h08);
    check({15'h0000, waveform_output_pin_b_o}, 16'h0001);
    wr16(timer16_pkg::OFS_CNT_LO, 16'h1232);
    ticks(4);
    rdchk(8'h38, 8'h18);
    wr(8'h38, 8'h08);
    rdchk(8'h38, 8'h10);
    wr(8'h38, 8'h00);
    rdchk(8'h38, 8'h10);
    wr16(timer16_pkg::OFS_CNT_LO, 16'hFFFE, 1'b1);
    ticks(3);
    rdchk(8'h38, 8'h14);
    wr(8'h39, 8'h3C);
    rdchk(8'h39, 8'h3C);
    wr(8'h39, 8'h14);
    repeat (3) @(posedge core_clk_i);
    check({12'h000, irq_request_o}, 16'h0000);
    global_irq_enable_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check({12'h000, irq_request_o}, 16'h0005);
    irq_vector_ack_i <= 4'h4;
    @(posedge core_clk_i);
    irq_vector_ack_i <= 4'h0;
    repeat (3) @(posedge core_clk_i);
    check({12'h000, irq_request_o}, 16'h0001);
    wr(8'h38, 8'h04);
    rdchk(8'h38, 8'h00);
    global_irq_enable_i <= 1'b0;
    // forced strobe toggles the pin but leaves the flags alone
    pin_a_old = waveform_output_pin_a_o;
    force_compare_a_strobe_i <= 1'b1;
    @(posedge core_clk_i);
    force_compare_a_strobe_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    check({15'h0000, waveform_output_pin_a_o}, {15'h0000, ~pin_a_old});
    rdchk(8'h38, 8'h00);
    // capture from the pin, then from the comparator
    for (int i = 0; i < 2; i++) begin
      wr16(timer16_pkg::OFS_CNT_LO, 16'h0A5C + 16'(i));
      @(posedge core_clk_i);
      capture_from_comparator_i <= i[0];
      capture_input_pin_i <= ~i[0];
      comparator_out_i <= i[0];
      repeat (8) @(posedge core_clk_i);
      rdchk(8'h26, 8'h5C + 8'(i));
      rdchk(8'h27, 8'h0A);
      rdchk(8'h38, 8'h20);
      wr(8'h38, 8'h20);
    end
    // capture as top: pin ignored, flag set when the count reaches it
    capture_from_comparator_i <= 1'b0;
    waveform_mode_select_i <= 4'hC;
    capture_input_pin_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check(counter_top_o, 16'h0A5D);
    rdchk(8'h26, 8'h5D);
    rdchk(8'h38, 8'h00);
    ticks(1);
    rdchk(8'h38, 8'h20);
    finish_test();
  end
endmodule // tb_timer16_compare_capture_regs
